// ==== rtl/cfp_pkg.sv ====
`default_nettype none
package cfp_pkg;
    // Protection configuration register fields
    localparam int          BIT_RAMP_CHECK_EN  = 7;
    localparam int          BIT_PHASE_ERR_EN   = 6;
    localparam int          BIT_RAMP_LATCH     = 5;
    localparam int          BIT_HEAT_LATCH     = 4;
    localparam int          BIT_CURRENT_LATCH  = 3;
    localparam int          BIT_LOW_V_LATCH    = 2;
    localparam int          BIT_HIGH_V_LATCH   = 1;
    localparam int          BIT_PHASE_LATCH    = 0;
    localparam logic [7:0]  PROT_CFG_RESET     = 8'h23;
    // Fault vector positions, flag register order
    localparam int          F_RAMP             = 5;
    localparam int          F_HEAT             = 4;
    localparam int          F_CURRENT          = 3;
    localparam int          F_LOW_V            = 2;
    localparam int          F_HIGH_V           = 1;
    localparam int          F_PHASE            = 0;
    localparam int          NFAULT             = 6;
    // Temperatures in degrees C
    localparam logic [7:0]  HEAT_TRIP_DEGC     = 8'h78;
    localparam logic [7:0]  HEAT_CLEAR_DEGC    = 8'h6e;
    // Voltages in millivolts
    localparam logic [15:0] RAMP_WINDOW_MV     = 16'h00fa;
    localparam logic [15:0] OV_FLOOR_MV        = 16'h01f4;
    localparam logic [15:0] OV_MARGIN_MV       = 16'h00fa;
    // Percent settings
    localparam logic [7:0]  OV_PCT_MIN         = 8'h6e;
    localparam logic [7:0]  OV_PCT_MAX         = 8'h82;
    // Retry time
    localparam int          CLK_HZ             = 20000000;
    localparam int          RETRY_MS           = 130;
    localparam int          RETRY_CYCLES       = CLK_HZ / 1000 * RETRY_MS;
    localparam int          TIMER_W            = 22;
    // Turn-off styles
    typedef enum logic [1:0]
    {
        CFP_OFF_SEQ  = 2'h0,
        CFP_OFF_CRIT = 2'h1,
        CFP_OFF_EMRG = 2'h2
    } cfp_off_type;
    // Converter states, one-hot
    typedef enum logic [3:0]
    {
        CFP_ST_RUN  = 4'h1,
        CFP_ST_SEQ  = 4'h2,
        CFP_ST_HALT = 4'h4,
        CFP_ST_WAIT = 4'h8
    } cfp_state_type;
endpackage
`default_nettype wire

// ==== rtl/cfp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfp_sync
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic pin,
    output logic      level
);
    // ****************************************
    // Three stage synchroniser with agreement
    // ****************************************
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic lv;
    } cfp_sync_type;
    cfp_sync_type r_q;
    cfp_sync_type r_d;
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = pin;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        if (r_q.s2 == r_q.s3)
        begin
            r_d.lv = r_q.s3;
        end
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end
    assign level = r_q.lv;
endmodule // cfp_sync
`default_nettype wire

// ==== rtl/cfp_ovth.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfp_ovth
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] target_mv,
    input  wire logic [7:0]  ov_pct,
    output logic      [15:0] thresh_mv
);
    // ****************************************
    // Overvoltage threshold from setpoint
    // ****************************************
    typedef struct packed
    {
        logic [15:0] th;
    } cfp_ovth_type;
    cfp_ovth_type r_q;
    cfp_ovth_type r_d;
    logic [7:0]  pct;
    logic [23:0] prod;
    logic [15:0] scaled;
    logic [16:0] plus;
    always_comb
    begin
        pct = ov_pct;
        if (pct < cfp_pkg::OV_PCT_MIN)
        begin
            pct = cfp_pkg::OV_PCT_MIN;
        end
        else if (pct > cfp_pkg::OV_PCT_MAX)
        begin
            pct = cfp_pkg::OV_PCT_MAX;
        end
        prod   = target_mv * pct;
        scaled = 16'((prod + 24'h000032) / 24'h000064);
        plus   = {1'b0, target_mv} + {1'b0, cfp_pkg::OV_MARGIN_MV};
        r_d.th = scaled;
        if (plus[16])
        begin
            r_d.th = 16'hffff;
        end
        else if (scaled < plus[15:0])
        begin
            r_d.th = plus[15:0];
        end
        if (r_d.th < cfp_pkg::OV_FLOOR_MV)
        begin
            r_d.th = cfp_pkg::OV_FLOOR_MV;
        end
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r_q.th <= cfp_pkg::OV_FLOOR_MV;
        end
        else
        begin
            r_q <= r_d;
        end
    end
    assign thresh_mv = r_q.th;
endmodule // cfp_ovth
`default_nettype wire

// ==== rtl/cfp_protect.sv ====
//Function
//- Undervoltage check armed only in steady regulation, never during ramps.
//- Output below undervoltage limit without current limit: fault, off, flag 0.
//- Undervoltage and overheat shutdowns selectable sequenced or critical.
//- Die above 120 C always raises heat fault, turns off, flag 0; code raises it only from the run state.
//- Non-latching heat fault restarts once die drops below 110 C.
//- Ramp tracking check armed only while output ramps up.
//- Tracking error above 250 mV: fault, both switches off, flag 0.
//- Config bit 7 enables tracking check, bit 6 enables phase error.
//- Margin limits apply to instantaneous ramp target and margin levels.
//- Tracking check stays disarmed during margining transitions.
//- Above prebias, output over threshold: error, off, flag 0.
//- Overvoltage with emergency style turns high side off and low side on together.
//- Overvoltage limit 110-130 percent, at least 0.5 V, setpoint plus 0.25 V.
//- Non-latching faults retry every 130 ms until condition clears.
//- Latching faults stay off until cleared, turn-on cycled or power cycled.
//- Config bits 5..0 select latching per fault in fixed order.
//- Turn-off style for heat, undervoltage, overvoltage each selectable.
//- Sequenced turn-off ramps down as a normal shutdown.
//- Critical turn-off opens both switches at once.
//- Emergency turn-off opens high side and closes low side.
//- Current limit blocks undervoltage fault; above prebias it also raises current fault.
`timescale 1ns/1ps
`default_nettype none
module cfp_protect
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic        cfg_we,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata,
    input  wire logic        flag_we,
    input  wire logic [5:0]  flag_wdata,
    output logic      [5:0]  fault_flag_reg,
    input  wire logic [1:0]  heat_off_style,
    input  wire logic [1:0]  low_v_off_style,
    input  wire logic [1:0]  high_v_off_style,
    input  wire logic [7:0]  ov_pct,
    // Converter state from regulation loop
    input  wire logic        turn_on_cmd,
    input  wire logic        ramping_up,
    input  wire logic        steady,
    input  wire logic        margining,
    input  wire logic        ramp_down_done,
    input  wire logic [15:0] vout_mv,
    input  wire logic [15:0] target_mv,
    input  wire logic [15:0] uv_thresh_mv,
    input  wire logic [15:0] prebias_mv,
    input  wire logic [7:0]  die_temp_degc,
    input  wire logic        current_limit_pin,
    input  wire logic        phase_error_pin,
    // Power stage control
    output logic             conv_enable,
    output logic             seq_ramp_down,
    output logic             high_side_en,
    output logic             low_side_force,
    output logic             low_side_block
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        cfp_pkg::cfp_state_type          st;
        logic [7:0]                      cfg;
        logic [cfp_pkg::NFAULT-1:0]      flag;
        logic [cfp_pkg::NFAULT-1:0]      cause;
        logic [cfp_pkg::NFAULT-1:0]      flag_n;
        logic [cfp_pkg::TIMER_W-1:0]     tmr;
        logic                            tdone;
        logic                            on_prev;
        logic                            cycled;
        logic                            margin_seen;
        logic                            en;
        logic                            seqd;
        logic                            hs;
        logic                            lsf;
        logic                            lsb;
    } cfp_protect_type;
    cfp_protect_type r_q;
    cfp_protect_type r_d;

    logic                       cur_lim;
    logic                       phase_err;
    logic [15:0]                ov_th;
    logic [cfp_pkg::NFAULT-1:0] det;
    logic [cfp_pkg::NFAULT-1:0] latch_sel;
    logic [cfp_pkg::NFAULT-1:0] cleared;
    logic [16:0]                diff;
    logic                       cond_now;
    logic                       heat_cond;
    cfp_pkg::cfp_off_type       style;
    logic                       any_new;

    cfp_sync u_sync_cl
    (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (current_limit_pin),
        .level   (cur_lim)
    );
    cfp_sync u_sync_pv
    (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (phase_error_pin),
        .level   (phase_err)
    );
    cfp_ovth u_ovth
    (
        .clk       (clk),
        .reset_n   (reset_n),
        .target_mv (target_mv),
        .ov_pct    (ov_pct),
        .thresh_mv (ov_th)
    );

    // ****************************************
    // Detection and response
    // ****************************************
    always_comb
    begin
        r_d      = r_q;
        diff     = (vout_mv >= target_mv) ?
                   {1'b0, vout_mv - target_mv} :
                   {1'b0, target_mv - vout_mv};
        det      = '0;
        // Tracking check only on ramp-up, never from margining
        det[cfp_pkg::F_RAMP] = r_q.cfg[cfp_pkg::BIT_RAMP_CHECK_EN]
            && ramping_up && !margining && !r_q.margin_seen
            && r_q.st == cfp_pkg::CFP_ST_RUN
            && diff > {1'b0, cfp_pkg::RAMP_WINDOW_MV};
        det[cfp_pkg::F_HEAT] = die_temp_degc > cfp_pkg::HEAT_TRIP_DEGC;
        det[cfp_pkg::F_CURRENT] = cur_lim && vout_mv > prebias_mv;
        det[cfp_pkg::F_LOW_V] = steady && !ramping_up
            && r_q.st == cfp_pkg::CFP_ST_RUN
            && vout_mv < uv_thresh_mv && !cur_lim;
        det[cfp_pkg::F_HIGH_V] = vout_mv > prebias_mv
            && vout_mv > ov_th;
        det[cfp_pkg::F_PHASE] = phase_err
            && r_q.cfg[cfp_pkg::BIT_PHASE_ERR_EN];

        latch_sel = r_q.cfg[5:0];
        cleared   = flag_we ? flag_wdata : '0;

        // Heat fault stays present until below the warning level
        heat_cond = r_q.cause[cfp_pkg::F_HEAT] ?
                    die_temp_degc >= cfp_pkg::HEAT_CLEAR_DEGC :
                    det[cfp_pkg::F_HEAT];
        cond_now  = heat_cond || (|(det & ~(6'h01 << cfp_pkg::F_HEAT)));

        // Pick the turn-off style of the most severe new fault
        any_new = (r_q.st == cfp_pkg::CFP_ST_RUN) && (|det);
        style   = cfp_pkg::CFP_OFF_SEQ;
        if (det[cfp_pkg::F_HIGH_V])
        begin
            style = cfp_pkg::cfp_off_type'(high_v_off_style);
        end
        else if (det[cfp_pkg::F_RAMP] || det[cfp_pkg::F_CURRENT]
                 || det[cfp_pkg::F_PHASE])
        begin
            style = cfp_pkg::CFP_OFF_CRIT;
        end
        else if (det[cfp_pkg::F_HEAT])
        begin
            style = (heat_off_style == 2'h1) ? cfp_pkg::CFP_OFF_CRIT
                  : cfp_pkg::CFP_OFF_SEQ;
        end
        else if (det[cfp_pkg::F_LOW_V])
        begin
            style = (low_v_off_style == 2'h1) ? cfp_pkg::CFP_OFF_CRIT
                  : cfp_pkg::CFP_OFF_SEQ;
        end

        // Flags: fault sets win over host clears
        r_d.flag = r_q.flag & ~cleared;
        r_d.flag = r_d.flag | (any_new ? det : '0);
        if (any_new)
        begin
            r_d.cause = det;
        end

        if (cfg_we)
        begin
            r_d.cfg = cfg_wdata;
        end

        r_d.on_prev = turn_on_cmd;
        if (r_q.on_prev && !turn_on_cmd)
        begin
            r_d.cycled = 1'b1;
        end
        if (steady && !margining)
        begin
            r_d.margin_seen = 1'b0;
        end
        else if (margining)
        begin
            r_d.margin_seen = 1'b1;
        end

        // Shared recovery timer
        if (r_q.tmr != '0)
        begin
            r_d.tmr = r_q.tmr - 1'b1;
        end
        r_d.tdone = (r_q.tmr == 22'h000001) || r_q.tdone;

        case (r_q.st)
            cfp_pkg::CFP_ST_RUN:
            begin
                r_d.en   = turn_on_cmd;
                r_d.hs   = turn_on_cmd;
                r_d.lsf  = 1'b0;
                r_d.lsb  = 1'b0;
                r_d.seqd = 1'b0;
                if (any_new)
                begin
                    r_d.tmr    = 22'(cfp_pkg::RETRY_CYCLES);
                    r_d.tdone  = 1'b0;
                    r_d.cycled = 1'b0;
                    r_d.en     = 1'b0;
                    if (style == cfp_pkg::CFP_OFF_EMRG)
                    begin
                        r_d.hs  = 1'b0;
                        r_d.lsf = 1'b1;
                        r_d.st  = cfp_pkg::CFP_ST_HALT;
                    end
                    else if (style == cfp_pkg::CFP_OFF_CRIT)
                    begin
                        r_d.hs  = 1'b0;
                        r_d.lsb = 1'b1;
                        r_d.st  = cfp_pkg::CFP_ST_HALT;
                    end
                    else
                    begin
                        r_d.en   = 1'b1;
                        r_d.seqd = 1'b1;
                        r_d.st   = cfp_pkg::CFP_ST_SEQ;
                    end
                end
            end
            cfp_pkg::CFP_ST_SEQ:
            begin
                if (ramp_down_done)
                begin
                    r_d.en   = 1'b0;
                    r_d.seqd = 1'b0;
                    r_d.hs   = 1'b0;
                    r_d.lsb  = 1'b1;
                    r_d.st   = cfp_pkg::CFP_ST_HALT;
                end
            end
            cfp_pkg::CFP_ST_HALT:
            begin
                if (r_q.tdone)
                begin
                    r_d.st = cfp_pkg::CFP_ST_WAIT;
                end
            end
            cfp_pkg::CFP_ST_WAIT:
            begin
                if (|(r_q.cause & latch_sel))
                begin
                    if (!cond_now && turn_on_cmd
                        && (!(|(r_q.cause & r_d.flag)) || r_q.cycled))
                    begin
                        r_d.st = cfp_pkg::CFP_ST_RUN;
                    end
                end
                else if (!cond_now)
                begin
                    r_d.st = cfp_pkg::CFP_ST_RUN;
                    r_d.flag = r_d.flag & ~r_q.cause;
                end
                else
                begin
                    r_d.tmr   = 22'(cfp_pkg::RETRY_CYCLES);
                    r_d.tdone = 1'b0;
                    r_d.st    = cfp_pkg::CFP_ST_HALT;
                end
                if (r_d.st == cfp_pkg::CFP_ST_RUN)
                begin
                    r_d.lsf = 1'b0;
                    r_d.lsb = 1'b0;
                end
            end
            default:
            begin
                r_d.st = cfp_pkg::CFP_ST_RUN;
            end
        endcase
        r_d.flag_n = ~r_d.flag;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r_q             <= '0;
            r_q.st          <= cfp_pkg::CFP_ST_RUN;
            r_q.cfg         <= cfp_pkg::PROT_CFG_RESET;
            r_q.flag_n      <= '1;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Flag register holds active faults as 0
    assign fault_flag_reg = r_q.flag_n;
    assign cfg_rdata      = r_q.cfg;
    assign conv_enable    = r_q.en;
    assign seq_ramp_down  = r_q.seqd;
    assign high_side_en   = r_q.hs;
    assign low_side_force = r_q.lsf;
    assign low_side_block = r_q.lsb;
endmodule // cfp_protect
`default_nettype wire

// ==== tb/cfp_loop_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfp_loop_model
#(
    parameter int RAMP = 40
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        conv_enable,
    input  wire logic        seq_ramp_down,
    input  wire logic [15:0] target_mv,
    input  wire logic [15:0] offset_mv,
    output logic             ramping_up,
    output logic             steady,
    output logic             ramp_down_done,
    output logic      [15:0] vout_mv
);
    // ****************************************
    // Regulation loop seen from the protection
    // ****************************************
    typedef struct packed
    {
        logic [7:0] cnt;
    } cfp_model_type;

    cfp_model_type state_q;
    cfp_model_type state_d;

    always_comb
    begin
        state_d = state_q;
        if (!conv_enable)
            state_d.cnt = 8'h00;
        else if (seq_ramp_down)
            state_d.cnt = (state_q.cnt == 8'h00) ? 8'h00 : state_q.cnt - 8'h01;
        else if (state_q.cnt < 8'(RAMP))
            state_d.cnt = state_q.cnt + 8'h01;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // Output follows the ramp target plus an injected error
    assign ramping_up     = conv_enable && !seq_ramp_down
                            && state_q.cnt < 8'(RAMP);
    assign steady         = conv_enable && !seq_ramp_down
                            && state_q.cnt == 8'(RAMP);
    assign ramp_down_done = seq_ramp_down && state_q.cnt == 8'h00;
    assign vout_mv        = conv_enable ? target_mv + offset_mv : 16'h0000;
endmodule // cfp_loop_model
`default_nettype wire

// ==== tb/cfp_protect_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfp_protect_asserts
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       cfg_we,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic [5:0] fault_flag_reg,
    input wire logic [1:0] low_v_off_style,
    input wire logic [1:0] high_v_off_style,
    input wire logic       ramping_up,
    input wire logic       steady,
    input wire logic [7:0] die_temp_degc,
    input wire logic       current_limit_pin,
    input wire logic       conv_enable,
    input wire logic       seq_ramp_down,
    input wire logic       high_side_en,
    input wire logic       low_side_force
);
    // ****************************************
    // Cycles since the most recent trip
    // ****************************************
    logic [5:0]  flag_prev_q;
    int unsigned since_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_prev_q <= 6'h3f;
            since_q     <= 32'hffffffff;
        end
        else
        begin
            flag_prev_q <= fault_flag_reg;
            if ((flag_prev_q & ~fault_flag_reg) != 6'h00)
                since_q <= 0;
            else if (since_q != 32'hffffffff)
                since_q <= since_q + 1;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence cl_held;
        current_limit_pin [*6];
    endsequence
    sequence low_v_trip;
        $fell(fault_flag_reg[cfp_pkg::F_LOW_V]);
    endsequence

    a_cfg_write:
        assert property (cfg_we |=> cfg_rdata == $past(cfg_wdata))
        else $error("config readback differs from last write");
    a_heat_trip:
        assert property ((die_temp_degc > cfp_pkg::HEAT_TRIP_DEGC
            && high_side_en && !seq_ramp_down)
            |=> !fault_flag_reg[cfp_pkg::F_HEAT])
        else $error("hot die did not raise heat fault");
    a_uv_steady:
        assert property (low_v_trip |-> $past(steady))
        else $error("low voltage fault outside steady regulation");
    a_uv_blocked:
        assert property (cl_held |-> !$fell(fault_flag_reg[cfp_pkg::F_LOW_V]))
        else $error("low voltage fault during current limit");
    a_uv_style:
        assert property (low_v_trip |-> ($past(low_v_off_style) == 2'h1)
            ? (!high_side_en && !low_side_force) : seq_ramp_down)
        else $error("low voltage turn-off style wrong");
    a_ramp_armed:
        assert property ($fell(fault_flag_reg[cfp_pkg::F_RAMP])
            |-> $past(ramping_up) && $past(cfg_rdata[7])
            && !high_side_en && !low_side_force)
        else $error("tracking fault outside ramp or not fast off");
    a_ov_style:
        assert property (($fell(fault_flag_reg[cfp_pkg::F_HIGH_V])
            && $past(high_v_off_style) == 2'h2)
            |-> !high_side_en && low_side_force)
        else $error("emergency off did not close low side");
    a_retry_hold:
        assert property ($rose(conv_enable)
            |-> since_q >= cfp_pkg::RETRY_CYCLES - 2)
        else $error("restart before retry time elapsed");
endmodule // cfp_protect_asserts

bind cfp_protect cfp_protect_asserts i_cfp_protect_asserts
(
    .clk, .reset_n, .cfg_we, .cfg_wdata, .cfg_rdata, .fault_flag_reg,
    .low_v_off_style, .high_v_off_style, .ramping_up, .steady,
    .die_temp_degc, .current_limit_pin, .conv_enable, .seq_ramp_down,
    .high_side_en, .low_side_force
);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, reset_n, cfg_we, flag_we, turn_on_cmd, margining;
    logic        current_limit_pin, phase_error_pin;
    logic        ramping_up, steady, ramp_down_done, conv_enable;
    logic        seq_ramp_down, high_side_en, low_side_force, low_side_block;
    logic [7:0]  cfg_wdata, cfg_rdata, ov_pct, die_temp_degc;
    logic [5:0]  flag_wdata, fault_flag_reg;
    logic [1:0]  heat_off_style, low_v_off_style, high_v_off_style;
    logic [15:0] vout_mv, target_mv, uv_thresh_mv, prebias_mv, offset_mv;
    int          errors, comparisons, cycles;

    always #25 clk = ~clk;

    cfp_protect i_cfp_protect
    (
        .clk, .reset_n, .cfg_we, .cfg_wdata, .cfg_rdata, .flag_we,
        .flag_wdata, .fault_flag_reg, .heat_off_style, .low_v_off_style,
        .high_v_off_style, .ov_pct, .turn_on_cmd, .ramping_up, .steady,
        .margining, .ramp_down_done, .vout_mv, .target_mv, .uv_thresh_mv,
        .prebias_mv, .die_temp_degc, .current_limit_pin, .phase_error_pin,
        .conv_enable, .seq_ramp_down, .high_side_en, .low_side_force,
        .low_side_block
    );

    cfp_loop_model #(.RAMP(40)) i_cfp_loop_model
    (
        .clk, .reset_n, .conv_enable, .seq_ramp_down, .target_mv,
        .offset_mv, .ramping_up, .steady, .ramp_down_done, .vout_mv
    );

    // ****************************************
    // Access tasks
    // ****************************************
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr_cfg(input logic [7:0] v);
        @(posedge clk);
        cfg_we    <= 1'b1;
        cfg_wdata <= v;
        @(posedge clk);
        cfg_we    <= 1'b0;
    endtask

    task wr_flag(input logic [5:0] v);
        @(posedge clk);
        flag_we    <= 1'b1;
        flag_wdata <= v;
        @(posedge clk);
        flag_we    <= 1'b0;
    endtask

    // Fresh power-up, configure, then command turn-on
    task boot(input logic [7:0] cfg);
        @(posedge clk);
        reset_n     <= 1'b0;
        turn_on_cmd <= 1'b0;
        tick(2);
        reset_n     <= 1'b1;
        wr_cfg(cfg);
        turn_on_cmd <= 1'b1;
    endtask

    task wait_steady;
        for (int i = 0; i < 200 && steady !== 1'b1; i++)
            tick(1);
        tick(1);
    endtask

    task finish_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        clk = 1'b0; reset_n = 1'b0; cfg_we = 1'b0; flag_we = 1'b0;
        cfg_wdata = 8'h00; flag_wdata = 6'h00; turn_on_cmd = 1'b0;
        margining = 1'b0; current_limit_pin = 1'b0; phase_error_pin = 1'b0;
        ov_pct = 8'h6e; die_temp_degc = 8'h19; heat_off_style = 2'h0;
        low_v_off_style = 2'h0; high_v_off_style = 2'h0;
        target_mv = 16'h03e8; uv_thresh_mv = 16'h0000;
        prebias_mv = 16'h0000; offset_mv = 16'hfefc;
        errors = 0; comparisons = 0; cycles = 0;
        tick(16);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("cfg_rdata", 16'(cfp_pkg::PROT_CFG_RESET), 16'(cfg_rdata));
        chk("flags", 16'h003f, 16'(fault_flag_reg));
        // Tracking disabled by default: 260 mV error ignored
        tick(1);
        turn_on_cmd <= 1'b1;
        tick(10);
        @(negedge clk);
        chk("flags", 16'h003f, 16'(fault_flag_reg));
        wait_steady();
        current_limit_pin <= 1'b1;
        tick(8);
        @(negedge clk);
        chk("flags", 16'h0037, 16'(fault_flag_reg));
        // Low output in steady state, sequenced off
        current_limit_pin <= 1'b0;
        offset_mv    <= 16'h0000;
        uv_thresh_mv <= 16'h0384;
        boot(cfp_pkg::PROT_CFG_RESET);
        wait_steady();
        offset_mv <= 16'hff38;
        tick(3);
        @(negedge clk);
        chk("flags", 16'h003b, 16'(fault_flag_reg));
        chk("seq_ramp_down", 16'h0001, 16'(seq_ramp_down));
        chk("conv_enable", 16'h0001, 16'(conv_enable));
        // Die heat, critical off, trip point boundary
        offset_mv      <= 16'h0000;
        uv_thresh_mv   <= 16'h0000;
        heat_off_style <= 2'h1;
        boot(cfp_pkg::PROT_CFG_RESET);
        wait_steady();
        die_temp_degc <= 8'h78;
        tick(3);
        @(negedge clk);
        chk("flags", 16'h003f, 16'(fault_flag_reg));
        die_temp_degc <= 8'h79;
        tick(3);
        @(negedge clk);
        chk("flags", 16'h002f, 16'(fault_flag_reg));
        chk("switches", 16'h0000, 16'({high_side_en, low_side_force}));
        chk("low_side_block", 16'h0001, 16'(low_side_block));
        chk("conv_enable", 16'h0000, 16'(conv_enable));
        // Overvoltage: limit is setpoint plus 250 mV at 110 percent
        die_temp_degc    <= 8'h19;
        high_v_off_style <= 2'h2;
        boot(cfp_pkg::PROT_CFG_RESET);
        wait_steady();
        offset_mv <= 16'h00f0;
        tick(4);
        @(negedge clk);
        chk("flags", 16'h003f, 16'(fault_flag_reg));
        offset_mv <= 16'h0104;
        tick(3);
        @(negedge clk);
        chk("flags", 16'h003d, 16'(fault_flag_reg));
        chk("switches", 16'h0001, 16'({high_side_en, low_side_force}));
        offset_mv <= 16'h0000;
        wr_flag(6'h02);
        tick(1);
        @(negedge clk);
        chk("flags", 16'h003f, 16'(fault_flag_reg));
        // Tracking enabled: 200 mV tolerated during ramp, 260 mV trips
        uv_thresh_mv <= 16'h0384;
        offset_mv    <= 16'hff38;
        boot(8'ha3);
        @(negedge clk);
        chk("cfg_rdata", 16'h00a3, 16'(cfg_rdata));
        tick(8);
        @(negedge clk);
        chk("flags", 16'h003f, 16'(fault_flag_reg));
        offset_mv <= 16'hfefc;
        tick(3);
        @(negedge clk);
        chk("flags", 16'h001f, 16'(fault_flag_reg));
        chk("switches", 16'h0000, 16'({high_side_en, low_side_force}));
        finish_test();
    end
endmodule // tb
`default_nettype wire
